// ==== core/vrs_pkg.sv ====
/*
 constants and types of the virtual register i2c slave.
 assumes a 20 MHz system clock.
*/
package vrs_pkg;
  localparam logic [6:0] DEV_ADDR7 = 7'h49;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_INBOUND = 8'h01;
  localparam logic [7:0] REG_OUTBOUND = 8'h02;
  localparam int BUSY_BIT = 1;
  localparam int RXV_BIT = 0;
  localparam int VWR_BIT = 7;
  localparam logic [7:0] NO_DATA = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCL_FAST_HZ = 400000;
  localparam int SCL_STD_HZ = 100000;
  // clocks per scl half period at fast mode, rounded down
  localparam int SCL_HALF_CYC = 1000000000 / (2 * SCL_FAST_HZ) / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_DEV = 4'h1,
    ST_DEVACK = 4'h2,
    ST_PTR = 4'h3,
    ST_PTRACK = 4'h4,
    ST_DATA = 4'h5,
    ST_DATAACK = 4'h6,
    ST_TX = 4'h7,
    ST_TXACK = 4'h8
  } vrs_fsm_type;

  typedef struct packed {
    logic write;
    logic [6:0] addr;
    logic [7:0] wdata;
  } vrs_vreq_type;

  typedef struct packed {
    vrs_fsm_type fsm;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic scl_q;
    logic sda_q;
    logic rw;
    logic [7:0] ptr;
    logic sda_oe;
    logic busy;
    logic rxv;
    logic [7:0] inb;
    logic [7:0] outb;
    logic exp_data;
    logic req;
    vrs_vreq_type vreq;
  } vrs_state_type;
endpackage : vrs_pkg

// ==== core/vrs_slave.sv ====
/*
 i2c slave with three physical byte registers giving polled access
 to a virtual register space served by the user-side port.
 assumes scl and sda are already synchronous to clock and that
 the pad logic resolves the open-drain sda from sda_oe.
*/
`timescale 1ns/1ps
`default_nettype none

module vrs_slave (
  input wire logic clock,
  input wire logic nrst,
  input wire logic host_port_select,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic vreg_req_valid,
  output vrs_pkg::vrs_vreq_type vreg_req,
  input wire logic vreg_ack,
  input wire logic [7:0] vreg_rdata
);

  vrs_pkg::vrs_state_type r;
  vrs_pkg::vrs_state_type d;
  logic rise;
  logic fall;
  logic start;
  logic stop;

  ////////////////////////////////////////////////////////////////
  // read side of the register map

  function automatic logic [7:0] rd_byte(input logic [7:0] ptr, input logic busy, input logic rxv,
                                         input logic [7:0] outb);
    logic [7:0] b;
    b = vrs_pkg::NO_DATA;
    if (ptr == vrs_pkg::REG_STATUS)
    begin
      b[vrs_pkg::BUSY_BIT] = busy;
      b[vrs_pkg::RXV_BIT] = rxv;
    end
    else if (ptr == vrs_pkg::REG_OUTBOUND)
    begin
      b = outb;
    end
    return b;
  endfunction : rd_byte

  ////////////////////////////////////////////////////////////////
  // bus conditions, sampled at 20 MHz

  assign rise = scl_in & ~r.scl_q;
  assign fall = ~scl_in & r.scl_q;
  assign start = scl_in & r.scl_q & r.sda_q & ~sda_in;
  assign stop = scl_in & r.scl_q & ~r.sda_q & sda_in;

  always_comb
  begin
    d = r;
    d.scl_q = scl_in;
    d.sda_q = sda_in;
    // virtual request completion
    if (r.req && vreg_ack)
    begin
      d.req = 1'b0;
      d.busy = 1'b0;
      if (!r.vreq.write)
      begin
        d.outb = vreg_rdata;
        d.rxv = 1'b1;
      end
    end
    // decode of a pending inbound byte
    if (r.busy && !r.req)
    begin
      if (r.exp_data)
      begin
        d.req = 1'b1;
        d.vreq.write = 1'b1;
        d.vreq.wdata = r.inb;
        d.exp_data = 1'b0;
      end
      else if (r.inb[vrs_pkg::VWR_BIT])
      begin
        d.vreq.addr = r.inb[6:0];
        d.exp_data = 1'b1;
        d.busy = 1'b0;
      end
      else
      begin
        d.req = 1'b1;
        d.vreq.write = 1'b0;
        d.vreq.addr = r.inb[6:0];
      end
    end
    // byte engine
    unique case (r.fsm)
      vrs_pkg::ST_IDLE:
      begin
        d.sda_oe = 1'b0;
      end
      vrs_pkg::ST_DEV, vrs_pkg::ST_PTR, vrs_pkg::ST_DATA:
      begin
        if (rise)
        begin
          d.sh = {r.sh[6:0], sda_in};
          d.cnt = r.cnt + 4'h1;
        end
        if (fall && r.cnt == vrs_pkg::BITS_PER_BYTE)
        begin
          d.cnt = 4'h0;
          d.sda_oe = 1'b1;
          if (r.fsm == vrs_pkg::ST_DEV)
          begin
            d.rw = r.sh[0];
            d.fsm = vrs_pkg::ST_DEVACK;
            if (r.sh[7:1] != vrs_pkg::DEV_ADDR7)
            begin
              d.sda_oe = 1'b0;
              d.fsm = vrs_pkg::ST_IDLE;
            end
          end
          else if (r.fsm == vrs_pkg::ST_PTR)
          begin
            d.ptr = r.sh;
            d.fsm = vrs_pkg::ST_PTRACK;
          end
          else
          begin
            d.fsm = vrs_pkg::ST_DATAACK;
            // status and outbound are read-only; busy refuses a write
            if (r.ptr == vrs_pkg::REG_INBOUND && !r.busy)
            begin
              d.inb = r.sh;
              d.busy = 1'b1;
            end
          end
        end
      end
      vrs_pkg::ST_DEVACK, vrs_pkg::ST_PTRACK, vrs_pkg::ST_DATAACK:
      begin
        if (fall)
        begin
          d.sda_oe = 1'b0;
          if (r.fsm == vrs_pkg::ST_DEVACK && r.rw)
          begin
            d.sh = rd_byte(r.ptr, d.busy, d.rxv, d.outb);
            d.sda_oe = ~d.sh[7];
            d.sh = {d.sh[6:0], 1'b0};
            d.fsm = vrs_pkg::ST_TX;
            if (r.ptr == vrs_pkg::REG_OUTBOUND)
            begin
              d.rxv = 1'b0;
            end
          end
          else if (r.fsm == vrs_pkg::ST_DEVACK)
          begin
            d.fsm = vrs_pkg::ST_PTR;
          end
          else
          begin
            d.fsm = vrs_pkg::ST_DATA;
          end
        end
      end
      vrs_pkg::ST_TX:
      begin
        if (rise)
        begin
          d.cnt = r.cnt + 4'h1;
        end
        if (fall)
        begin
          if (r.cnt == vrs_pkg::BITS_PER_BYTE)
          begin
            d.sda_oe = 1'b0;
            d.cnt = 4'h0;
            d.fsm = vrs_pkg::ST_TXACK;
          end
          else
          begin
            d.sda_oe = ~r.sh[7];
            d.sh = {r.sh[6:0], 1'b0};
          end
        end
      end
      vrs_pkg::ST_TXACK:
      begin
        if (rise && sda_in)
        begin
          d.fsm = vrs_pkg::ST_IDLE;
        end
        else if (fall)
        begin
          d.sh = rd_byte(r.ptr, d.busy, d.rxv, d.outb);
          d.sda_oe = ~d.sh[7];
          d.sh = {d.sh[6:0], 1'b0};
          d.fsm = vrs_pkg::ST_TX;
          if (r.ptr == vrs_pkg::REG_OUTBOUND)
          begin
            d.rxv = 1'b0;
          end
        end
      end
      default:
      begin
        d.fsm = vrs_pkg::ST_IDLE;
        d.sda_oe = 1'b0;
      end
    endcase
    // a completing virtual read sets ready over a same-cycle clear
    if (r.req && vreg_ack && !r.vreq.write)
    begin
      d.rxv = 1'b1;
    end
    if (start)
    begin
      d.fsm = vrs_pkg::ST_DEV;
      d.cnt = 4'h0;
      d.sda_oe = 1'b0;
    end
    else if (stop)
    begin
      d.fsm = vrs_pkg::ST_IDLE;
      d.sda_oe = 1'b0;
    end
    if (!host_port_select)
    begin
      d.fsm = vrs_pkg::ST_IDLE;
      d.sda_oe = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      r <= '0;
      r.scl_q <= 1'b1;
      r.sda_q <= 1'b1;
    end
    else
    begin
      r <= d;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = r.sda_oe;
  assign vreg_req_valid = r.req;
  assign vreg_req = r.vreq;

  ////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  sequence addr_byte_s;
    r.busy && !r.req && !r.exp_data && r.inb[7];
  endsequence
  sequence read_byte_s;
    r.busy && !r.req && !r.exp_data && !r.inb[7];
  endsequence
  sequence rd_done_s;
    r.req && vreg_ack && !r.vreq.write;
  endsequence

  port_off_a: assert property (!host_port_select |=> !sda_oe)
    else $error("sda driven while i2c not selected");
  addr_ack_a: assert property ($rose(r.sda_oe) && r.fsm == vrs_pkg::ST_DEVACK
                               |-> r.sh[7:1] == vrs_pkg::DEV_ADDR7)
    else $error("acked a foreign device address");
  busy_set_a: assert property (r.fsm == vrs_pkg::ST_DATA && fall && r.cnt == vrs_pkg::BITS_PER_BYTE
                               && r.ptr == vrs_pkg::REG_INBOUND && !(r.req && vreg_ack) |=> r.busy)
    else $error("inbound write did not raise busy");
  wr_follow_a: assert property (addr_byte_s |=> r.exp_data && !r.busy ##1 !vreg_req_valid)
    else $error("write address not held for data");
  wdata_issue_a: assert property (r.busy && !r.req && r.exp_data
                                  |=> vreg_req_valid && vreg_req.write
                                  && vreg_req.wdata == $past(r.inb))
    else $error("write data not forwarded");
  rd_issue_a: assert property (read_byte_s |=> vreg_req_valid && !vreg_req.write
                               && vreg_req.addr == $past(r.inb[6:0]))
    else $error("virtual read not issued");
  rd_ready_a: assert property (rd_done_s |=> r.rxv && r.outb == $past(vreg_rdata)
                               && !r.busy)
    else $error("read result not presented");
  rxv_clear_a: assert property (r.fsm == vrs_pkg::ST_DEVACK && fall && r.rw
                                && r.ptr == vrs_pkg::REG_OUTBOUND && !(r.req && vreg_ack)
                                |=> !r.rxv)
    else $error("ready not cleared by outbound read");

endmodule : vrs_slave

`default_nettype wire

// ==== tb/testbench.sv ====
/*
 self-checking bench for the virtual register i2c slave.
 assumes vrs_slave and the master model; inputs change on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock, nrst, host_port_select, sda_out, sda_oe, vreg_req_valid, vreg_ack, scl, sda_drv, sda, a, fire;
  logic [7:0] vreg_rdata, d, acks;
  vrs_pkg::vrs_vreq_type vreg_req, last_req;
  int failures, n_compared, resp_delay, wait_cnt, n_req;
  logic [15:0] rows [4] = '{16'h0000, 16'h0100, 16'h0500, 16'hFF00};
  assign sda = sda_drv & ~(sda_oe & ~sda_out);
  vrs_slave vrs_slave_inst (.clock(clock), .nrst(nrst), .host_port_select(host_port_select), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .vreg_req_valid(vreg_req_valid), .vreg_req(vreg_req),
    .vreg_ack(vreg_ack), .vreg_rdata(vreg_rdata));
  vrs_i2c_master vrs_i2c_master_inst (.clock(clock), .scl(scl), .sda_drv(sda_drv), .sda(sda));
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] vmap(input logic [6:0] x);
    return {x, 1'b1};
  endfunction : vmap
  assign fire = vreg_req_valid && !vreg_ack && wait_cnt >= resp_delay;
  always @(negedge clock)
  begin
    vreg_ack <= fire;
    vreg_rdata <= fire ? vmap(vreg_req.addr) : ~vreg_rdata;
    wait_cnt <= (vreg_req_valid && !fire) ? wait_cnt + 1 : 0;
    if (fire)
    begin
      last_req <= vreg_req;
      n_req <= n_req + 1;
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic poll(input int b, input logic v);
    d = 'x;
    for (int k = 0; k < 40 && d[b] !== v; k++)
      vrs_i2c_master_inst.rd_reg(8'h00, d, acks);
    chk8({7'h00, d[b]}, {7'h00, v});
  endtask : poll
  task automatic summarize();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  initial
  begin
    #(50 * 80000);
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize();
  end
  ////////////////////////////////////////////////////////////////
  initial
  begin
    {failures, n_compared, n_req, wait_cnt} = '0;
    {nrst, vreg_ack, vreg_rdata} = '0;
    host_port_select = 1'b1;
    resp_delay = 1;
    repeat (2) @(negedge clock);
    nrst = 1'b1;
    repeat (3) @(negedge clock);
    for (int i = 0; i < 4; i++)
    begin
      vrs_i2c_master_inst.rd_reg(rows[i][15:8], d, acks);
      chk8(d, rows[i][7:0]);
      chk8(acks, 8'h00);
    end
    vrs_i2c_master_inst.wr_reg(8'h00, 8'hFF, acks);
    poll(1, 1'b0);
    vrs_i2c_master_inst.wr_reg(8'h01, 8'h85, acks);
    poll(1, 1'b0);
    chk8(n_req[7:0], 8'h00);
    vrs_i2c_master_inst.wr_reg(8'h01, 8'h3C, acks);
    poll(1, 1'b0);
    chk8({last_req.write, last_req.addr}, 8'h85);
    chk8(last_req.wdata, 8'h3C);
    vrs_i2c_master_inst.wr_reg(8'h01, 8'h12, acks);
    poll(0, 1'b1);
    vrs_i2c_master_inst.rd_reg(8'h02, d, acks);
    chk8(d, vmap(7'h12));
    vrs_i2c_master_inst.rd_reg(8'h00, d, acks);
    chk8(d, 8'h00);
    resp_delay = 600;
    vrs_i2c_master_inst.wr_reg(8'h01, 8'h21, acks);
    vrs_i2c_master_inst.rd_reg(8'h00, d, acks);
    chk8(d, 8'h02);
    vrs_i2c_master_inst.wr_reg(8'h01, 8'h33, acks);
    chk8(acks, 8'h00);
    poll(0, 1'b1);
    vrs_i2c_master_inst.ph_n = 1000000000 / (2 * vrs_pkg::SCL_STD_HZ) / vrs_pkg::CLK_PERIOD_NS;
    vrs_i2c_master_inst.rd_reg(8'h00, d, acks);
    chk8(d, 8'h01);
    chk8(acks, 8'h00);
    vrs_i2c_master_inst.ph_n = vrs_pkg::SCL_HALF_CYC;
    vrs_i2c_master_inst.rd_reg(8'h02, d, acks);
    chk8(d, vmap(7'h21));
    chk8(acks, 8'h00);
    vrs_i2c_master_inst.ph_n = 3;
    chk8(n_req[7:0], 8'h03);
    vrs_i2c_master_inst.probe(8'h94, a);
    chk8({7'h00, a}, 8'h01);
    host_port_select = 1'b0;
    vrs_i2c_master_inst.probe(8'h92, a);
    chk8({7'h00, a}, 8'h01);
    host_port_select = 1'b1;
    vrs_i2c_master_inst.wr_reg(8'h01, 8'h44, acks);
    repeat (5) @(negedge clock);
    nrst = 1'b0;
    @(negedge clock);
    chk8({6'h00, sda_oe, vreg_req_valid}, 8'h00);
    nrst = 1'b1;
    repeat (3) @(negedge clock);
    vrs_i2c_master_inst.rd_reg(8'h00, d, acks);
    chk8(d, 8'h00);
    summarize();
  end
endmodule : testbench
`default_nettype wire

// ==== tb/vrs_i2c_master.sv ====
/*
 i2c master model driving the slave's bus.
 assumes the bench resolves sda with a pull-up; changes on falling clock edges.
*/
`timescale 1ns/1ps
`default_nettype none
module vrs_i2c_master (
  input wire logic clock,
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  // clock periods per scl phase; the bench sets it per bus rate
  int ph_n = 3;
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  ////////////////////////////////////////////////////////////////
  task automatic ph(input logic c, input logic d);
    scl = c;
    sda_drv = d;
    repeat (ph_n) @(negedge clock);
  endtask : ph
  task automatic start_c();
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
    ph(1'b0, 1'b0);
  endtask : start_c
  task automatic stop_c();
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask : stop_c
  task automatic bit_c(input logic b, output logic r);
    ph(1'b0, b);
    scl = 1'b1;
    repeat (ph_n - 1) @(negedge clock);
    r = sda;
    @(negedge clock);
    scl = 1'b0;
    @(negedge clock);
  endtask : bit_c
  // one byte out, then the ninth bit; single-byte units
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_c(d[i], r[i]);
    bit_c(mack, a);
  endtask : xfer
  ////////////////////////////////////////////////////////////////
  // pointer then one data byte
  task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] d, output logic [7:0] acks);
    logic [7:0] r;
    acks = 8'h00;
    start_c();
    xfer(8'h92, 1'b1, r, acks[0]);
    xfer(ptr, 1'b1, r, acks[1]);
    xfer(d, 1'b1, r, acks[2]);
    stop_c();
  endtask : wr_reg
  // pointer, repeated start, one byte then nack
  task automatic rd_reg(input logic [7:0] ptr, output logic [7:0] d, output logic [7:0] acks);
    logic [7:0] r;
    logic nk;
    acks = 8'h00;
    start_c();
    xfer(8'h92, 1'b1, r, acks[0]);
    xfer(ptr, 1'b1, r, acks[1]);
    start_c();
    xfer(8'h93, 1'b1, r, acks[2]);
    xfer(8'hFF, 1'b1, d, nk);
    stop_c();
  endtask : rd_reg
  task automatic probe(input logic [7:0] a, output logic ack);
    logic [7:0] r;
    start_c();
    xfer(a, 1'b1, r, ack);
    stop_c();
  endtask : probe
endmodule : vrs_i2c_master
`default_nettype wire
